// ### core/tile_debug_config_registers.sv
// Purpose: Tile debug and configuration register bank with watchpoint trigger logic
// Assumes: All inputs synchronous to ref_clk; indices are register numbers
// Notes:   Read data and ack appear one cycle after the request
// Functional notes
// - Four read/write second comparison addresses, one per data watchpoint.
// - Bits 23:16 of each watch control enable the watchpoint per thread.
// - Data watch control bit 2 lets loads trigger the watchpoint.
// - Data watch control bit 1 picks A and B, or A or B.
// - Control bit 0 enables a watchpoint; cleared means it never fires.
// - Four read/write resource watch mask registers.
// - Four read/write resource watch value registers, paired with the masks.
// - Resource watch control bit 1 picks condition A or condition B.
// - Tile configuration space is reached by configuration reads and writes; scratch also by debug ones.
// - Identification register is read-only: processor, node, revision, version.
// - First description holds channel ends, locks, synchronisers; low byte reads zero.
// - Second description holds clock blocks and timers; upper half reads zero.
// - A set permission bit blocks writes to writable configuration registers.
// - Permission bit 31 blocks writes from every source.
// - Permission bit 0 blocks writes from the system network switch only.
// - Writing one to request bit 0 raises a debug interrupt.
// - Request register bit 1 reads one while the processor is in debug mode.
// - Eight read-only program counter copies at consecutive indices.
// - Eight read-only status word copies at consecutive indices.
// - Four read/write first comparison addresses, one per data watchpoint.
// - A trigger raises the debug interrupt and records cause 4, 5 or 1.
`timescale 1ns/1ps
module tile_debug_config_registers #(
	parameter logic [7:0] PROC_ID      = 8'h00, // Arbitrary value
	parameter logic [7:0] NODE_NUM     = 8'h00,
	parameter logic [7:0] REVISION     = 8'h01, // Arbitrary value
	parameter logic [7:0] VERSION      = 8'h01, // Arbitrary value
	parameter logic [7:0] N_CHANENDS   = 8'h20,
	parameter logic [7:0] N_LOCKS      = 8'h04,
	parameter logic [7:0] N_SYNCS      = 8'h07,
	parameter logic [7:0] N_CLKBLKS    = 8'h06,
	parameter logic [7:0] N_TIMERS     = 8'h0a
) (
	input  wire logic                                          ref_clk,
	input  wire logic                                          rst_n,
	input  wire logic                                          cfg_req,
	input  wire logic                                          cfg_write,
	input  wire tile_dbg_pkg::cfg_src_t                        cfg_src,
	input  wire logic [7:0]                                    cfg_addr,
	input  wire logic [31:0]                                   cfg_wdata,
	output logic [31:0]                                        cfg_rdata,
	output logic                                               cfg_ack,
	output logic                                               cfg_refused,
	input  wire logic                                          dbg_req,
	input  wire logic                                          dbg_write,
	input  wire logic [7:0]                                    dbg_addr,
	input  wire logic [31:0]                                   dbg_wdata,
	output logic [31:0]                                        dbg_rdata,
	output logic                                               dbg_ack,
	input  wire logic                                          mem_valid,
	input  wire logic                                          mem_load,
	input  wire logic [31:0]                                   mem_addr,
	input  wire logic [2:0]                                    mem_thread,
	input  wire logic                                          res_valid,
	input  wire logic [31:0]                                   res_id,
	input  wire logic [2:0]                                    res_thread,
	input  wire logic [tile_dbg_pkg::N_CORE-1:0][31:0]         program_counter,
	input  wire logic [tile_dbg_pkg::N_CORE-1:0][31:0]         core_status_word,
	input  wire logic                                          debug_mode,
	output logic                                               debug_irq,
	output logic [2:0]                                         irq_cause,
	output logic [1:0]                                         irq_watch_num,
	output logic [7:0]                                         irq_thread,
	output logic [31:0]                                        irq_data
);
	import tile_dbg_pkg::*;

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [N_CORE-1:0][31:0] scratch_q;
	logic [31:0]             perm_q;
	logic                    host_req_q;
	logic                    dmode_q;
	logic [31:0]             cfg_rdata_d;
	logic [31:0]             dbg_rdata_d;
	irq_state_t              state_q;
	logic [3:0][31:0]        addr1_q;
	logic [3:0][31:0]        addr2_q;
	logic [3:0][31:0]        dctrl_q;
	logic [3:0][31:0]        rmask_q;
	logic [3:0][31:0]        rval_q;
	logic [3:0][31:0]        rctrl_q;
	logic                    cfg_wr;
	logic                    cfg_target;
	logic                    cfg_blocked;
	logic                    cfg_wr_ok;
	logic                    dbg_wr;

	watch_if w ();

	assign w.addr1      = addr1_q;
	assign w.addr2      = addr2_q;
	assign w.dctrl      = dctrl_q;
	assign w.rmask      = rmask_q;
	assign w.rval       = rval_q;
	assign w.rctrl      = rctrl_q;
	assign w.mem_valid  = mem_valid;
	assign w.mem_load   = mem_load;
	assign w.mem_addr   = mem_addr;
	assign w.mem_thread = mem_thread;
	assign w.res_valid  = res_valid;
	assign w.res_id     = res_id;
	assign w.res_thread = res_thread;

	watch_match u_match (
		.w (w.match)
	);

	// ----------------------------------------
	// Configuration write permission
	// ----------------------------------------
	assign cfg_wr      = cfg_req && cfg_write;
	assign cfg_target  = (cfg_addr == CFG_PERM) || (cfg_addr == CFG_IRQ) || in_block(cfg_addr, CFG_SCRATCH, 3);
	assign cfg_blocked = perm_q[PERM_ALL_BIT]
		|| (perm_q[PERM_SW_BIT] && (cfg_src == SRC_SYSTEM_NETWORK_SWITCH));
	assign cfg_wr_ok   = cfg_wr && cfg_target && !cfg_blocked;
	assign dbg_wr      = dbg_req && dbg_write;

	// The permission word guards itself too, so a set bit 31 holds until reset
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			perm_q <= RESET_WORD;
		end else if (cfg_wr_ok && cfg_addr == CFG_PERM) begin
			perm_q <= cfg_wdata & PERM_MASK;
		end
	end

	// Scratch is shared by both spaces; the configuration side wins a clash
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			scratch_q <= '0;
		end else if (cfg_wr_ok && in_block(cfg_addr, CFG_SCRATCH, 3)) begin
			scratch_q[cfg_addr[2:0]] <= cfg_wdata;
		end else if (dbg_wr && in_block(dbg_addr, DBG_SCRATCH, 3)) begin
			scratch_q[dbg_addr[2:0]] <= dbg_wdata;
		end
	end

	// A new request written in the cycle it is taken is kept
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			host_req_q <= 1'b0;
		end else if (cfg_wr_ok && cfg_addr == CFG_IRQ && cfg_wdata[IRQ_REQ_BIT]) begin
			host_req_q <= 1'b1;
		end else if (state_q == IRQ_IDLE && w.data_hit == 4'h0 && w.res_hit == 4'h0) begin
			host_req_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dmode_q <= 1'b0;
		end else begin
			dmode_q <= debug_mode;
		end
	end

	// ----------------------------------------
	// Watchpoint registers
	// ----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr1_q <= '0;
			addr2_q <= '0;
			rmask_q <= '0;
			rval_q  <= '0;
		end else if (dbg_wr) begin
			if (in_block(dbg_addr, DBG_ADDR1, 2)) addr1_q[dbg_addr[1:0]] <= dbg_wdata;
			if (in_block(dbg_addr, DBG_ADDR2, 2)) addr2_q[dbg_addr[1:0]] <= dbg_wdata;
			if (in_block(dbg_addr, DBG_RMASK, 2)) rmask_q[dbg_addr[1:0]] <= dbg_wdata;
			if (in_block(dbg_addr, DBG_RVAL, 2)) rval_q[dbg_addr[1:0]] <= dbg_wdata;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dctrl_q <= '0;
			rctrl_q <= '0;
		end else if (dbg_wr) begin
			if (in_block(dbg_addr, DBG_DCTRL, 2)) dctrl_q[dbg_addr[1:0]] <= dbg_wdata & DCTRL_MASK;
			if (in_block(dbg_addr, DBG_RCTRL, 2)) rctrl_q[dbg_addr[1:0]] <= dbg_wdata & RCTRL_MASK;
		end
	end

	// ----------------------------------------
	// Read paths
	// ----------------------------------------
	always_comb begin
		cfg_rdata_d = RESET_WORD;
		if (cfg_addr == CFG_ID) begin
			cfg_rdata_d = {PROC_ID, NODE_NUM, REVISION, VERSION};
		end else if (cfg_addr == CFG_DESC_A) begin
			cfg_rdata_d = {N_CHANENDS, N_LOCKS, N_SYNCS, 8'h00};
		end else if (cfg_addr == CFG_DESC_B) begin
			cfg_rdata_d = {16'h0000, N_CLKBLKS, N_TIMERS};
		end else if (cfg_addr == CFG_PERM) begin
			cfg_rdata_d = perm_q;
		end else if (cfg_addr == CFG_IRQ) begin
			cfg_rdata_d = {30'h0, dmode_q, host_req_q};
		end else if (in_block(cfg_addr, CFG_SCRATCH, 3)) begin
			cfg_rdata_d = scratch_q[cfg_addr[2:0]];
		end else if (in_block(cfg_addr, CFG_PC, 3)) begin
			cfg_rdata_d = program_counter[cfg_addr[2:0]];
		end else if (in_block(cfg_addr, CFG_SR, 3)) begin
			cfg_rdata_d = core_status_word[cfg_addr[2:0]];
		end
	end

	always_comb begin
		dbg_rdata_d = RESET_WORD;
		if (in_block(dbg_addr, DBG_SCRATCH, 3)) begin
			dbg_rdata_d = scratch_q[dbg_addr[2:0]];
		end else if (in_block(dbg_addr, DBG_ADDR1, 2)) begin
			dbg_rdata_d = addr1_q[dbg_addr[1:0]];
		end else if (in_block(dbg_addr, DBG_ADDR2, 2)) begin
			dbg_rdata_d = addr2_q[dbg_addr[1:0]];
		end else if (in_block(dbg_addr, DBG_DCTRL, 2)) begin
			dbg_rdata_d = dctrl_q[dbg_addr[1:0]];
		end else if (in_block(dbg_addr, DBG_RMASK, 2)) begin
			dbg_rdata_d = rmask_q[dbg_addr[1:0]];
		end else if (in_block(dbg_addr, DBG_RVAL, 2)) begin
			dbg_rdata_d = rval_q[dbg_addr[1:0]];
		end else if (in_block(dbg_addr, DBG_RCTRL, 2)) begin
			dbg_rdata_d = rctrl_q[dbg_addr[1:0]];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg_rdata   <= RESET_WORD;
			cfg_ack     <= 1'b0;
			cfg_refused <= 1'b0;
		end else begin
			cfg_rdata   <= cfg_req ? cfg_rdata_d : RESET_WORD;
			cfg_ack     <= cfg_req;
			cfg_refused <= cfg_wr && cfg_target && cfg_blocked;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			dbg_rdata <= RESET_WORD;
			dbg_ack   <= 1'b0;
		end else begin
			dbg_rdata <= dbg_req ? dbg_rdata_d : RESET_WORD;
			dbg_ack   <= dbg_req;
		end
	end

	// ----------------------------------------
	// Debug interrupt sequencing
	// ----------------------------------------
	// Triggers are only taken in idle, so a burst of hits during debug is dropped
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q       <= IRQ_IDLE;
			irq_cause     <= 3'h0;
			irq_watch_num <= 2'h0;
			irq_thread    <= 8'h00;
			irq_data      <= RESET_WORD;
		end else begin
			case (state_q)
				IRQ_IDLE: begin
					if (w.data_hit != 4'h0) begin
						state_q       <= IRQ_PEND;
						irq_cause     <= CAUSE_DATA;
						irq_watch_num <= lowest_index(w.data_hit);
						irq_thread    <= {5'h00, mem_thread};
						irq_data      <= mem_addr;
					end else if (w.res_hit != 4'h0) begin
						state_q       <= IRQ_PEND;
						irq_cause     <= CAUSE_RES;
						irq_watch_num <= lowest_index(w.res_hit);
						irq_thread    <= {5'h00, res_thread};
						irq_data      <= res_id;
					end else if (host_req_q) begin
						state_q       <= IRQ_PEND;
						irq_cause     <= CAUSE_HOST;
						irq_watch_num <= 2'h0;
						irq_thread    <= 8'h00;
						irq_data      <= RESET_WORD;
					end
				end
				IRQ_PEND: begin
					if (debug_mode) state_q <= IRQ_DEBUG;
				end
				IRQ_DEBUG: begin
					if (!debug_mode) state_q <= IRQ_IDLE;
				end
				default: state_q <= IRQ_IDLE;
			endcase
		end
	end

	assign debug_irq = (state_q == IRQ_PEND);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_host_write;
		cfg_wr_ok && cfg_addr == CFG_IRQ && cfg_wdata[IRQ_REQ_BIT];
	endsequence
	sequence s_host_taken;
		state_q == IRQ_IDLE && w.data_hit == 4'h0 && w.res_hit == 4'h0;
	endsequence

	a_host_irq_raise: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_host_write ##1 s_host_taken |=> debug_irq && irq_cause == CAUSE_HOST)
		else $error("host request did not raise debug interrupt");
	a_data_trig_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_q == IRQ_IDLE && w.data_hit != 4'h0 |=> debug_irq && irq_cause == CAUSE_DATA
		&& irq_data == $past(mem_addr))
		else $error("data watch trigger not recorded");
	a_res_trig_cause: assert property (@(posedge ref_clk) disable iff (!rst_n)
		state_q == IRQ_IDLE && w.data_hit == 4'h0 && w.res_hit != 4'h0 |=> debug_irq
		&& irq_cause == CAUSE_RES)
		else $error("resource watch trigger not recorded");
	a_enable_gates_hit: assert property (@(posedge ref_clk) disable iff (!rst_n)
		w.data_hit[0] |-> dctrl_q[0][CTL_EN_BIT] && thread_on(dctrl_q[0], mem_thread))
		else $error("disabled data watchpoint fired");
	a_load_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
		w.data_hit[1] && mem_load |-> dctrl_q[1][CTL_LOAD_BIT])
		else $error("load fired without load enable");
	a_lock_all_writes: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cfg_wr && perm_q[PERM_ALL_BIT] && cfg_addr == CFG_PERM |=> $stable(perm_q) && cfg_refused)
		else $error("write passed with bit 31 set");
	a_switch_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cfg_wr && perm_q[PERM_SW_BIT] && cfg_src == SRC_SYSTEM_NETWORK_SWITCH && cfg_addr == CFG_IRQ
		|=> cfg_refused)
		else $error("switch write passed with bit 0 set");
	a_id_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cfg_req && cfg_addr == CFG_ID |=> cfg_ack && cfg_rdata == {PROC_ID, NODE_NUM, REVISION, VERSION})
		else $error("identification read wrong");
	a_pc_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cfg_req && in_block(cfg_addr, CFG_PC, 3) |=> cfg_rdata == $past(program_counter[cfg_addr[2:0]]))
		else $error("program counter copy wrong");
	a_debug_bit_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		debug_mode ##1 (cfg_req && cfg_addr == CFG_IRQ) |=> cfg_rdata[IRQ_DBG_BIT])
		else $error("debug mode bit not shown");
	a_addr2_store: assert property (@(posedge ref_clk) disable iff (!rst_n)
		dbg_wr && dbg_addr == DBG_ADDR2 |=> addr2_q[0] == $past(dbg_wdata))
		else $error("second address not stored");
endmodule // tile_debug_config_registers

// ### core/tile_dbg_pkg.sv
// Purpose: Shared offsets, field positions and types of the tile debug register bank
// Assumes: Register indices are word indices, not byte addresses
// Notes:   Two spaces: tile configuration space and watchpoint debug space
package tile_dbg_pkg;
	// ----------------------------------------
	// Sizes and offsets
	// ----------------------------------------
	localparam int unsigned N_WATCH     = 4;
	localparam int unsigned N_CORE      = 8;
	localparam logic [7:0]  CFG_ID      = 8'h00;
	localparam logic [7:0]  CFG_DESC_A  = 8'h01;
	localparam logic [7:0]  CFG_DESC_B  = 8'h02;
	localparam logic [7:0]  CFG_PERM    = 8'h04;
	localparam logic [7:0]  CFG_IRQ     = 8'h05;
	localparam logic [7:0]  CFG_SCRATCH = 8'h20;
	localparam logic [7:0]  CFG_PC      = 8'h40;
	localparam logic [7:0]  CFG_SR      = 8'h60;
	localparam logic [7:0]  DBG_SCRATCH = 8'h20;
	localparam logic [7:0]  DBG_ADDR1   = 8'h50;
	localparam logic [7:0]  DBG_ADDR2   = 8'h60;
	localparam logic [7:0]  DBG_DCTRL   = 8'h70;
	localparam logic [7:0]  DBG_RMASK   = 8'h80;
	localparam logic [7:0]  DBG_RVAL    = 8'h90;
	localparam logic [7:0]  DBG_RCTRL   = 8'h9c;
	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int unsigned CTL_EN_BIT   = 0;
	localparam int unsigned CTL_MODE_BIT = 1;
	localparam int unsigned CTL_LOAD_BIT = 2;
	localparam int unsigned CTL_THR_LSB  = 16;
	localparam int unsigned PERM_ALL_BIT = 31;
	localparam int unsigned PERM_SW_BIT  = 0;
	localparam int unsigned IRQ_REQ_BIT  = 0;
	localparam int unsigned IRQ_DBG_BIT  = 1;
	localparam logic [31:0] DCTRL_MASK   = 32'h00ff_0007;
	localparam logic [31:0] RCTRL_MASK   = 32'h00ff_0003;
	localparam logic [31:0] PERM_MASK    = 32'h8000_0001;
	localparam logic [31:0] RESET_WORD   = 32'h0000_0000;
	localparam logic [2:0]  CAUSE_HOST   = 3'h1;
	localparam logic [2:0]  CAUSE_DATA   = 3'h4;
	localparam logic [2:0]  CAUSE_RES    = 3'h5;
	// ----------------------------------------
	// Types and helpers
	// ----------------------------------------
	typedef enum logic [1:0] {
		SRC_SYSTEM_NETWORK_SWITCH = 2'h0,
		SRC_CORE_SCRATCH_PATH     = 2'h1,
		SRC_TEST_PORT             = 2'h2
	} cfg_src_t;
	typedef enum logic [1:0] {
		IRQ_IDLE  = 2'b00,
		IRQ_PEND  = 2'b01,
		IRQ_DEBUG = 2'b11
	} irq_state_t;

	// Address falls in an aligned block of 2**lg entries at base
	function automatic logic in_block(input logic [7:0] a, input logic [7:0] base, input int unsigned lg);
		return (a >> lg) == (base >> lg);
	endfunction

	// Lowest set index wins when several watchpoints fire together
	function automatic logic [1:0] lowest_index(input logic [3:0] v);
		logic [1:0] r;
		r = 2'h0;
		for (int i = 3; i >= 0; i--) begin
			if (v[i]) r = 2'(i);
		end
		return r;
	endfunction

	function automatic logic thread_on(input logic [31:0] ctl, input logic [2:0] thr);
		return ctl[CTL_THR_LSB + int'(thr)];
	endfunction
endpackage

// ### core/watch_if.sv
// Purpose: Carries watchpoint settings and observed operations to the matcher
// Assumes: One tile clock; the matcher is purely combinational
// Notes:   Hits return to the register bank
`timescale 1ns/1ps
interface watch_if;
	logic [3:0][31:0] addr1;
	logic [3:0][31:0] addr2;
	logic [3:0][31:0] dctrl;
	logic [3:0][31:0] rmask;
	logic [3:0][31:0] rval;
	logic [3:0][31:0] rctrl;
	logic             mem_valid;
	logic             mem_load;
	logic [31:0]      mem_addr;
	logic [2:0]       mem_thread;
	logic             res_valid;
	logic [31:0]      res_id;
	logic [2:0]       res_thread;
	logic [3:0]       data_hit;
	logic [3:0]       res_hit;
	modport regs  (output addr1, addr2, dctrl, rmask, rval, rctrl, mem_valid, mem_load, mem_addr,
		mem_thread, res_valid, res_id, res_thread, input data_hit, res_hit);
	modport match (input addr1, addr2, dctrl, rmask, rval, rctrl, mem_valid, mem_load, mem_addr,
		mem_thread, res_valid, res_id, res_thread, output data_hit, res_hit);
endinterface

// ### core/watch_match.sv
// Purpose: Decides which data and resource watchpoints fire this cycle
// Assumes: Operations are presented for one cycle with their thread number
// Notes:   Stores always qualify; loads only when the load bit is set
`timescale 1ns/1ps
module watch_match (
	watch_if.match w
);
	import tile_dbg_pkg::*;

	always_comb begin
		logic a_hit;
		logic b_hit;
		logic r_eq;
		a_hit = 1'b0;
		b_hit = 1'b0;
		r_eq  = 1'b0;
		for (int i = 0; i < N_WATCH; i++) begin
			a_hit = w.mem_addr == w.addr1[i];
			b_hit = w.mem_addr == w.addr2[i];
			w.data_hit[i] = w.mem_valid && w.dctrl[i][CTL_EN_BIT]
				&& thread_on(w.dctrl[i], w.mem_thread)
				&& (!w.mem_load || w.dctrl[i][CTL_LOAD_BIT])
				&& (w.dctrl[i][CTL_MODE_BIT] ? (a_hit || b_hit) : (a_hit && b_hit));
			// Condition B is taken as the mismatch of the same masked compare
			r_eq = (w.res_id & w.rmask[i]) == w.rval[i];
			w.res_hit[i] = w.res_valid && w.rctrl[i][CTL_EN_BIT]
				&& thread_on(w.rctrl[i], w.res_thread)
				&& (w.rctrl[i][CTL_MODE_BIT] ? !r_eq : r_eq);
		end
	end
endmodule // watch_match

// ### dv/core_model.sv
// Purpose: Processor side of the bank: live program counters, status words and debug mode
// Assumes: debug_irq is a level that stands until debug mode is seen
// Notes:   Slow entry on purpose, so the request level must stand for several cycles
`timescale 1ns/1ps
module core_model (
	input  wire logic                                  ref_clk,
	input  wire logic                                  debug_irq,
	output logic [tile_dbg_pkg::N_CORE-1:0][31:0]      program_counter,
	output logic [tile_dbg_pkg::N_CORE-1:0][31:0]      core_status_word,
	output logic                                       debug_mode
);
	int unsigned cnt    = 0;
	logic        mode_q = 1'b0;
	assign debug_mode = mode_q;
	always_comb for (int i = 0; i < 8; i++) begin
		program_counter[i] = 32'h1000_0000 + 32'(i);
		core_status_word[i] = 32'h0000_0100 + 32'(i);
	end
	// Enter debug mode four cycles after the request, leave six cycles later
	always @(posedge ref_clk) begin
		cnt <= (debug_irq || mode_q) ? cnt + 1 : 0;
		if (cnt == 3) mode_q <= 1'b1;
		if (cnt == 9) mode_q <= 1'b0;
	end
endmodule // core_model

// ### dv/test_tile_debug_config_registers.sv
// Purpose: Self-checking bench of the tile debug and configuration bank
// Assumes: Default identity and count parameters
// Notes:   Table of reads first, then watchpoint, host request and permission cases
`timescale 1ns/1ps
module test_tile_debug_config_registers;
	import tile_dbg_pkg::*;
	typedef struct {bit d; logic [7:0] a; logic [31:0] e;} row_t;
	logic ref_clk = 1'b0, rst_n = 1'b0, cfg_req = 1'b0, cfg_write = 1'b0, dbg_req = 1'b0, dbg_write = 1'b0;
	logic mem_valid = 1'b0, mem_load = 1'b0, res_valid = 1'b0, cfg_ack, cfg_refused, dbg_ack, debug_mode, debug_irq;
	cfg_src_t cfg_src = SRC_SYSTEM_NETWORK_SWITCH;
	logic [7:0] cfg_addr = 8'h00, dbg_addr = 8'h00, irq_thread;
	logic [31:0] cfg_wdata = 32'h0, dbg_wdata = 32'h0, mem_addr = 32'h0, res_id = 32'h0, cfg_rdata, dbg_rdata, irq_data, rd;
	logic [2:0] mem_thread = 3'h0, res_thread = 3'h0, irq_cause;
	logic [1:0] irq_watch_num;
	logic [N_CORE-1:0][31:0] pc, sr;
	logic rf;
	int n_fail = 0, n_tests = 0;
	row_t rows[12] = '{'{0, 8'h00, 32'h0000_0101}, '{0, 8'h01, 32'h2004_0700}, '{0, 8'h02, 32'h0000_060a},
		'{0, 8'h04, 32'h0}, '{0, 8'h05, 32'h0}, '{0, 8'h40, 32'h1000_0000}, '{0, 8'h47, 32'h1000_0007},
		'{0, 8'h60, 32'h0000_0100}, '{0, 8'h67, 32'h0000_0107}, '{0, 8'h10, 32'h0}, '{1, 8'h70, 32'h0}, '{1, 8'h9c, 32'h0}};
	always #4 ref_clk = ~ref_clk;
	tile_debug_config_registers tile_debug_config_registers_inst (.ref_clk, .rst_n, .cfg_req, .cfg_write, .cfg_src,
		.cfg_addr, .cfg_wdata, .cfg_rdata, .cfg_ack, .cfg_refused, .dbg_req, .dbg_write, .dbg_addr, .dbg_wdata,
		.dbg_rdata, .dbg_ack, .mem_valid, .mem_load, .mem_addr, .mem_thread, .res_valid, .res_id, .res_thread,
		.program_counter(pc), .core_status_word(sr), .debug_mode, .debug_irq, .irq_cause, .irq_watch_num,
		.irq_thread, .irq_data);
	core_model core_model_inst (.ref_clk(ref_clk), .debug_irq(debug_irq), .program_counter(pc),
		.core_status_word(sr), .debug_mode(debug_mode));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic acc(bit d, bit wr, cfg_src_t s, logic [7:0] a, logic [31:0] wd);
		@(posedge ref_clk);
		cfg_req <= !d;
		dbg_req <= d;
		cfg_write <= wr;
		dbg_write <= wr;
		cfg_src <= s;
		cfg_addr <= a;
		dbg_addr <= a;
		cfg_wdata <= wd;
		dbg_wdata <= wd;
		@(posedge ref_clk);
		cfg_req <= 1'b0;
		dbg_req <= 1'b0;
		#1 rd = d ? dbg_rdata : cfg_rdata;
		rf = cfg_refused;
		chk("ack", 32'h1, {31'h0, d ? dbg_ack : cfg_ack});
	endtask
	task automatic op(bit r, logic [31:0] v, logic [2:0] t, bit ld, logic e);
		@(posedge ref_clk);
		mem_valid <= !r;
		res_valid <= r;
		mem_load <= ld;
		mem_addr <= v;
		res_id <= v;
		mem_thread <= t;
		res_thread <= t;
		@(posedge ref_clk);
		mem_valid <= 1'b0;
		res_valid <= 1'b0;
		#1 chk("debug_irq", {31'h0, e}, {31'h0, debug_irq});
	endtask
	// Waits out the partner's debug episode under a bound
	task automatic settle();
		for (int i = 0; i < 40 && (debug_irq !== 1'b0 || debug_mode !== 1'b0); i++) begin
			@(posedge ref_clk);
			#1;
		end
		repeat (2) @(posedge ref_clk);
		chk("irq released", 32'h0, {31'h0, debug_irq});
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#200us;
		n_fail++;
		stop_test();
	end
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			acc(rows[i].d, 0, SRC_SYSTEM_NETWORK_SWITCH, rows[i].a, 32'h0);
			chk("table read", rows[i].e, rd);
		end
		acc(0, 1, SRC_TEST_PORT, 8'h00, 32'hffff_ffff);
		acc(0, 0, SRC_TEST_PORT, 8'h00, 32'h0);
		chk("id after write", 32'h0000_0101, rd);
		// Plain value blocks only; the control block at 0x70 masks its writes
		for (int b = 0; b < 4; b++) for (int w = 0; w < 4; w++) begin
			acc(1, 1, SRC_TEST_PORT, 8'h50 + 8'((b + (b > 1)) * 16) + 8'(w), 32'ha5a5_5a00 + 32'(b * 4 + w));
			acc(1, 0, SRC_TEST_PORT, 8'h50 + 8'((b + (b > 1)) * 16) + 8'(w), 32'h0);
			chk("watch reg", 32'ha5a5_5a00 + 32'(b * 4 + w), rd);
		end
		acc(1, 1, SRC_TEST_PORT, 8'h70, 32'hffff_ffff);
		acc(1, 0, SRC_TEST_PORT, 8'h70, 32'h0);
		chk("data ctrl mask", 32'h00ff_0007, rd);
		acc(1, 1, SRC_TEST_PORT, 8'h9c, 32'hffff_ffff);
		acc(1, 0, SRC_TEST_PORT, 8'h9c, 32'h0);
		chk("res ctrl mask", 32'h00ff_0003, rd);
		$display("registers done");
		acc(1, 1, SRC_TEST_PORT, 8'h50, 32'h0000_4000);
		acc(1, 1, SRC_TEST_PORT, 8'h70, 32'h0008_0003);
		op(0, 32'h4000, 3'h3, 1, 0);
		op(0, 32'h4000, 3'h2, 0, 0);
		op(0, 32'h4000, 3'h3, 0, 1);
		chk("cause data", {29'h0, CAUSE_DATA}, {29'h0, irq_cause});
		chk("data addr", 32'h4000, irq_data);
		chk("thread", 32'h3, {24'h0, irq_thread});
		chk("data watch num", 32'h0, {30'h0, irq_watch_num});
		settle();
		acc(1, 1, SRC_TEST_PORT, 8'h70, 32'h0008_0001);
		op(0, 32'h4000, 3'h3, 0, 0);
		acc(1, 1, SRC_TEST_PORT, 8'h70, 32'h0008_0002);
		op(0, 32'h4000, 3'h3, 0, 0);
		acc(1, 1, SRC_TEST_PORT, 8'h80, 32'h0000_00ff);
		acc(1, 1, SRC_TEST_PORT, 8'h90, 32'h0000_0012);
		acc(1, 1, SRC_TEST_PORT, 8'h9c, 32'h0001_0001);
		op(1, 32'h3412, 3'h0, 0, 1);
		chk("cause res", {29'h0, CAUSE_RES}, {29'h0, irq_cause});
		chk("res id", 32'h3412, irq_data);
		settle();
		acc(1, 1, SRC_TEST_PORT, 8'h9c, 32'h0);
		acc(1, 1, SRC_TEST_PORT, 8'h81, 32'h0000_00ff);
		acc(1, 1, SRC_TEST_PORT, 8'h91, 32'h0000_0012);
		acc(1, 1, SRC_TEST_PORT, 8'h9d, 32'h0001_0003);
		op(1, 32'h3412, 3'h0, 0, 0);
		op(1, 32'h3400, 3'h0, 0, 1);
		chk("res watch num", 32'h1, {30'h0, irq_watch_num});
		settle();
		$display("watchpoints done");
		acc(0, 1, SRC_TEST_PORT, 8'h05, 32'h1);
		@(posedge ref_clk);
		#1 chk("host irq", 32'h1, {31'h0, debug_irq});
		chk("cause host", {29'h0, CAUSE_HOST}, {29'h0, irq_cause});
		for (int i = 0; i < 20 && debug_mode !== 1'b1; i++) @(posedge ref_clk);
		acc(0, 0, SRC_TEST_PORT, 8'h05, 32'h0);
		chk("debug mode bit", 32'h2, rd);
		settle();
		$display("host request done");
		acc(0, 1, SRC_CORE_SCRATCH_PATH, 8'h20, 32'h22);
		acc(0, 1, SRC_SYSTEM_NETWORK_SWITCH, 8'h04, 32'h1);
		acc(0, 1, SRC_SYSTEM_NETWORK_SWITCH, 8'h20, 32'h11);
		chk("switch refused", 32'h1, {31'h0, rf});
		acc(0, 1, SRC_SYSTEM_NETWORK_SWITCH, 8'h05, 32'h1);
		chk("switch irq refused", 32'h1, {31'h0, rf});
		acc(0, 1, SRC_CORE_SCRATCH_PATH, 8'h04, 32'h8000_0001);
		chk("path allowed", 32'h0, {31'h0, rf});
		acc(0, 1, SRC_TEST_PORT, 8'h20, 32'h33);
		chk("test port refused", 32'h1, {31'h0, rf});
		acc(1, 0, SRC_TEST_PORT, 8'h20, 32'h0);
		chk("scratch kept", 32'h22, rd);
		acc(0, 1, SRC_CORE_SCRATCH_PATH, 8'h04, 32'h0);
		chk("lock refused", 32'h1, {31'h0, rf});
		acc(0, 0, SRC_TEST_PORT, 8'h04, 32'h0);
		chk("permission", 32'h8000_0001, rd);
		$display("permissions done");
		// The lock only clears through reset, which must act without a clock edge
		rst_n <= 1'b0;
		#1 chk("reset rdata", 32'h0, cfg_rdata);
		@(posedge ref_clk);
		rst_n <= 1'b1;
		acc(0, 0, SRC_TEST_PORT, 8'h04, 32'h0);
		chk("permission reset", 32'h0, rd);
		$display("reset done");
		stop_test();
	end
endmodule // test_tile_debug_config_registers
